// ### verilog/vcc_pkg.sv
// Register map, field layout and encodings of the voltage comparator control.
// Assumes a 32-bit AXI4-Lite bus with word-aligned register addresses.
package vcc_pkg;
	// ==========================================================
	// Register byte offsets.
	localparam logic [11:0] OFF_TASK_START = 12'h000;
	localparam logic [11:0] OFF_TASK_STOP = 12'h004;
	localparam logic [11:0] OFF_TASK_SAMPLE = 12'h008;
	localparam logic [11:0] OFF_EV_READY = 12'h100;
	localparam logic [11:0] OFF_EV_DOWN = 12'h104;
	localparam logic [11:0] OFF_EV_UP = 12'h108;
	localparam logic [11:0] OFF_EV_CROSS = 12'h10c;
	localparam logic [11:0] OFF_RESULT = 12'h400;
	localparam logic [11:0] OFF_ENABLE = 12'h500;
	localparam logic [11:0] OFF_PIN_SELECT = 12'h504;
	localparam logic [11:0] OFF_REF_CHOICE = 12'h508;
	localparam logic [11:0] OFF_EXT_REF_CHOICE = 12'h50c;
	localparam logic [11:0] OFF_LADDER_LEVELS = 12'h530;
	localparam logic [11:0] OFF_MODE = 12'h534;
	localparam logic [11:0] OFF_BAND_ENABLE = 12'h538;
	// ==========================================================
	// Field layout.
	localparam int ADDR_W = 12;
	localparam int SEL_W = 3;
	localparam int TAP_W = 6;
	localparam int SPEED_W = 2;
	localparam int ENABLE_W = 2;
	localparam int LOWER_TAP_LSB = 0;
	localparam int UPPER_TAP_LSB = 8;
	localparam int SPEED_LSB = 0;
	localparam int MAIN_MODE_BIT = 8;
	localparam logic [ENABLE_W-1:0] ENABLE_ON = 2'h2;
	localparam logic [SEL_W-1:0] PIN_SEL_HALF_SUPPLY = 3'h7;
	// ==========================================================
	// Encodings of the reference source choice.
	localparam logic [SEL_W-1:0] REF_INT_1V2 = 3'h0;
	localparam logic [SEL_W-1:0] REF_INT_1V8 = 3'h1;
	localparam logic [SEL_W-1:0] REF_INT_2V4 = 3'h2;
	localparam logic [SEL_W-1:0] REF_SUPPLY = 3'h4;
	localparam logic [SEL_W-1:0] REF_PIN = 3'h5;
	// ==========================================================
	// Speed settings and AXI responses.
	localparam logic [SPEED_W-1:0] SPEED_LOW_POWER = 2'h0;
	localparam logic [SPEED_W-1:0] SPEED_NORMAL = 2'h1;
	localparam logic [SPEED_W-1:0] SPEED_HIGH = 2'h2;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage

// ### verilog/vcc_top.sv
// Voltage comparator control: AXI4-Lite registers, tasks, events, result.
// Assumes an analog core whose output and ready lines are asynchronous.
//
// The register offsets and the AXI4-Lite slave port were chosen for this implementation.
`timescale 1ns/10ps

module vcc_top (
	input wire logic clock,
	input wire logic rst_n,
	input wire logic [11:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [11:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic comp_out_async,
	input wire logic core_ready_async,
	input wire logic ref_ready_async,
	output logic pins_acquired,
	output logic core_power,
	output logic differential_mode,
	output logic [1:0] speed_setting,
	output logic [2:0] positive_input_select,
	output logic [2:0] reference_source_choice,
	output logic [2:0] external_pin_reference_choice,
	output logic [5:0] active_ladder_tap,
	output logic band_active
);
	// ==========================================================
	// Address decode helper.
	function automatic logic hit(input logic [11:0] a, input logic [11:0] o);
		hit = (a[11:2] == o[11:2]);
	endfunction
	// ==========================================================
	// Bus state.
	logic aw_held_reg;
	logic w_held_reg;
	logic [11:0] awaddr_reg;
	logic [31:0] wdata_reg;
	logic [3:0] wstrb_reg;
	logic bvalid_reg;
	logic [1:0] bresp_reg;
	logic rvalid_reg;
	logic [31:0] rdata_reg;
	logic [1:0] rresp_reg;

	// Configuration and status.
	logic [1:0] enable_reg;
	logic [2:0] psel_reg;
	logic [2:0] reference_source_choice_reg;
	logic [2:0] extref_reg;
	logic [5:0] upper_tap_reg;
	logic [5:0] lower_tap_reg;
	logic [1:0] speed_reg;
	logic diff_reg;
	logic band_reg;
	logic running_reg;
	logic ready_done_reg;
	logic result_reg;
	logic ev_ready_reg;
	logic ev_down_reg;
	logic ev_up_reg;
	logic ev_cross_reg;

	// Synchronisers.
	logic [1:0] comp_sync_reg;
	logic [1:0] core_sync_reg;
	logic [1:0] ref_sync_reg;
	logic comp_prev_reg;

	// ==========================================================
	// Write channel decode.
	wire do_write = aw_held_reg && w_held_reg && !bvalid_reg;
	wire wb0 = wstrb_reg[0];
	wire wb1 = wstrb_reg[1];
	wire w_bit = wdata_reg[0];
	wire w_start = do_write && hit(awaddr_reg, vcc_pkg::OFF_TASK_START);
	wire w_stop = do_write && hit(awaddr_reg, vcc_pkg::OFF_TASK_STOP);
	wire w_sample = do_write && hit(awaddr_reg, vcc_pkg::OFF_TASK_SAMPLE);
	wire w_ev_ready = do_write && wb0 && hit(awaddr_reg, vcc_pkg::OFF_EV_READY);
	wire w_ev_down = do_write && wb0 && hit(awaddr_reg, vcc_pkg::OFF_EV_DOWN);
	wire w_ev_up = do_write && wb0 && hit(awaddr_reg, vcc_pkg::OFF_EV_UP);
	wire w_ev_cross = do_write && wb0 && hit(awaddr_reg, vcc_pkg::OFF_EV_CROSS);
	wire w_enable = do_write && wb0 && hit(awaddr_reg, vcc_pkg::OFF_ENABLE);
	wire w_psel = do_write && wb0 && hit(awaddr_reg, vcc_pkg::OFF_PIN_SELECT);
	wire w_ref = do_write && wb0 && hit(awaddr_reg, vcc_pkg::OFF_REF_CHOICE);
	wire w_ext = do_write && wb0 &&
		hit(awaddr_reg, vcc_pkg::OFF_EXT_REF_CHOICE);
	wire th_hit = hit(awaddr_reg, vcc_pkg::OFF_LADDER_LEVELS);
	wire mode_hit = hit(awaddr_reg, vcc_pkg::OFF_MODE);
	wire w_band = do_write && wb0 && hit(awaddr_reg, vcc_pkg::OFF_BAND_ENABLE);
	wire wr_mapped = w_start || w_stop || w_sample ||
		hit(awaddr_reg, vcc_pkg::OFF_EV_READY) ||
		hit(awaddr_reg, vcc_pkg::OFF_EV_DOWN) ||
		hit(awaddr_reg, vcc_pkg::OFF_EV_UP) ||
		hit(awaddr_reg, vcc_pkg::OFF_EV_CROSS) ||
		hit(awaddr_reg, vcc_pkg::OFF_RESULT) ||
		hit(awaddr_reg, vcc_pkg::OFF_ENABLE) ||
		hit(awaddr_reg, vcc_pkg::OFF_PIN_SELECT) ||
		hit(awaddr_reg, vcc_pkg::OFF_REF_CHOICE) ||
		hit(awaddr_reg, vcc_pkg::OFF_EXT_REF_CHOICE) ||
		th_hit || mode_hit ||
		hit(awaddr_reg, vcc_pkg::OFF_BAND_ENABLE);

	// ==========================================================
	// Comparator control decode.
	wire enabled = (enable_reg == vcc_pkg::ENABLE_ON);
	wire start_task = w_start && w_bit && enabled;
	wire stop_task = (w_stop && w_bit) ||
		(w_enable && wdata_reg[1:0] != vcc_pkg::ENABLE_ON);
	wire comp_s = comp_sync_reg[1];
	wire int_ref_used = !diff_reg &&
		(reference_source_choice_reg == vcc_pkg::REF_INT_1V2 ||
		reference_source_choice_reg == vcc_pkg::REF_INT_1V8 ||
		reference_source_choice_reg == vcc_pkg::REF_INT_2V4);
	wire ref_ok = !int_ref_used || ref_sync_reg[1];
	wire ready_set = running_reg && !ready_done_reg &&
		core_sync_reg[1] && ref_ok;
	wire crossing = running_reg && (comp_s != comp_prev_reg);
	wire up_set = crossing && comp_s;
	wire down_set = crossing && !comp_s;
	wire running_next = enabled && (start_task || (running_reg && !stop_task));
	wire band_next = (w_band && diff_reg) ? w_bit : band_reg;

	// ==========================================================
	// Read decode.
	logic [31:0] rd_value;
	logic rd_mapped;
	always_comb begin
		rd_value = 32'h0000_0000;
		rd_mapped = 1'b1;
		if (hit(s_axi_araddr, vcc_pkg::OFF_EV_READY)) begin
			rd_value[0] = ev_ready_reg;
		end else if (hit(s_axi_araddr, vcc_pkg::OFF_EV_DOWN)) begin
			rd_value[0] = ev_down_reg;
		end else if (hit(s_axi_araddr, vcc_pkg::OFF_EV_UP)) begin
			rd_value[0] = ev_up_reg;
		end else if (hit(s_axi_araddr, vcc_pkg::OFF_EV_CROSS)) begin
			rd_value[0] = ev_cross_reg;
		end else if (hit(s_axi_araddr, vcc_pkg::OFF_RESULT)) begin
			rd_value[0] = result_reg;
		end else if (hit(s_axi_araddr, vcc_pkg::OFF_ENABLE)) begin
			rd_value[1:0] = enable_reg;
		end else if (hit(s_axi_araddr, vcc_pkg::OFF_PIN_SELECT)) begin
			rd_value[2:0] = psel_reg;
		end else if (hit(s_axi_araddr, vcc_pkg::OFF_REF_CHOICE)) begin
			rd_value[2:0] = reference_source_choice_reg;
		end else if (hit(s_axi_araddr, vcc_pkg::OFF_EXT_REF_CHOICE)) begin
			rd_value[2:0] = extref_reg;
		end else if (hit(s_axi_araddr, vcc_pkg::OFF_LADDER_LEVELS)) begin
			rd_value[vcc_pkg::LOWER_TAP_LSB +: vcc_pkg::TAP_W] = lower_tap_reg;
			rd_value[vcc_pkg::UPPER_TAP_LSB +: vcc_pkg::TAP_W] = upper_tap_reg;
		end else if (hit(s_axi_araddr, vcc_pkg::OFF_MODE)) begin
			rd_value[vcc_pkg::SPEED_LSB +: vcc_pkg::SPEED_W] = speed_reg;
			rd_value[vcc_pkg::MAIN_MODE_BIT] = diff_reg;
		end else if (hit(s_axi_araddr, vcc_pkg::OFF_BAND_ENABLE)) begin
			rd_value[0] = band_reg;
		end else if (hit(s_axi_araddr, vcc_pkg::OFF_TASK_START) ||
			hit(s_axi_araddr, vcc_pkg::OFF_TASK_STOP) ||
			hit(s_axi_araddr, vcc_pkg::OFF_TASK_SAMPLE)) begin
			rd_value = 32'h0000_0000;
		end else begin
			rd_mapped = 1'b0;
		end
	end

	// ==========================================================
	// AXI4-Lite handshakes.
	assign s_axi_awready = !aw_held_reg;
	assign s_axi_wready = !w_held_reg;
	assign s_axi_bvalid = bvalid_reg;
	assign s_axi_bresp = bresp_reg;
	assign s_axi_arready = !rvalid_reg;
	assign s_axi_rvalid = rvalid_reg;
	assign s_axi_rdata = rdata_reg;
	assign s_axi_rresp = rresp_reg;

	always_ff @(posedge clock) begin
		if (!rst_n) begin
			aw_held_reg <= 1'b0;
			w_held_reg <= 1'b0;
			awaddr_reg <= 12'h000;
			wdata_reg <= 32'h0000_0000;
			wstrb_reg <= 4'h0;
			bvalid_reg <= 1'b0;
			bresp_reg <= vcc_pkg::RESP_OKAY;
		end else begin
			if (s_axi_awvalid && !aw_held_reg) begin
				aw_held_reg <= 1'b1;
				awaddr_reg <= s_axi_awaddr;
			end
			if (s_axi_wvalid && !w_held_reg) begin
				w_held_reg <= 1'b1;
				wdata_reg <= s_axi_wdata;
				wstrb_reg <= s_axi_wstrb;
			end
			if (do_write) begin
				bvalid_reg <= 1'b1;
				bresp_reg <= wr_mapped ? vcc_pkg::RESP_OKAY : vcc_pkg::RESP_SLVERR;
			end else if (bvalid_reg && s_axi_bready) begin
				bvalid_reg <= 1'b0;
				aw_held_reg <= 1'b0;
				w_held_reg <= 1'b0;
			end
		end
	end

	always_ff @(posedge clock) begin
		if (!rst_n) begin
			rvalid_reg <= 1'b0;
			rdata_reg <= 32'h0000_0000;
			rresp_reg <= vcc_pkg::RESP_OKAY;
		end else if (s_axi_arvalid && !rvalid_reg) begin
			rvalid_reg <= 1'b1;
			rdata_reg <= rd_value;
			rresp_reg <= rd_mapped ? vcc_pkg::RESP_OKAY : vcc_pkg::RESP_SLVERR;
		end else if (rvalid_reg && s_axi_rready) begin
			rvalid_reg <= 1'b0;
		end
	end

	// ==========================================================
	// Configuration registers.
	always_ff @(posedge clock) begin
		if (!rst_n) begin
			enable_reg <= 2'h0;
			psel_reg <= 3'h0;
			reference_source_choice_reg <= vcc_pkg::REF_INT_1V2;
			extref_reg <= 3'h0;
			upper_tap_reg <= 6'h00;
			lower_tap_reg <= 6'h00;
			speed_reg <= vcc_pkg::SPEED_LOW_POWER;
			diff_reg <= 1'b0;
			band_reg <= 1'b0;
		end else begin
			if (w_enable) enable_reg <= wdata_reg[1:0];
			if (w_psel) psel_reg <= wdata_reg[2:0];
			if (w_ref) reference_source_choice_reg <= wdata_reg[2:0];
			if (w_ext) extref_reg <= wdata_reg[2:0];
			if (do_write && th_hit && wb0) begin
				lower_tap_reg <= wdata_reg[vcc_pkg::LOWER_TAP_LSB +: vcc_pkg::TAP_W];
			end
			if (do_write && th_hit && wb1) begin
				upper_tap_reg <= wdata_reg[vcc_pkg::UPPER_TAP_LSB +: vcc_pkg::TAP_W];
			end
			if (do_write && mode_hit && wb0) begin
				speed_reg <= wdata_reg[vcc_pkg::SPEED_LSB +: vcc_pkg::SPEED_W];
			end
			if (do_write && mode_hit && wb1) begin
				diff_reg <= wdata_reg[vcc_pkg::MAIN_MODE_BIT];
			end
			band_reg <= band_next;
		end
	end

	// ==========================================================
	// Synchronisers, run state, result and events.
	always_ff @(posedge clock) begin
		if (!rst_n) begin
			comp_sync_reg <= 2'b00;
			core_sync_reg <= 2'b00;
			ref_sync_reg <= 2'b00;
			comp_prev_reg <= 1'b0;
		end else begin
			comp_sync_reg <= {comp_sync_reg[0], comp_out_async};
			core_sync_reg <= {core_sync_reg[0], core_ready_async};
			ref_sync_reg <= {ref_sync_reg[0], ref_ready_async};
			comp_prev_reg <= comp_s;
		end
	end

	always_ff @(posedge clock) begin
		if (!rst_n) begin
			running_reg <= 1'b0;
			ready_done_reg <= 1'b0;
			result_reg <= 1'b0;
		end else begin
			running_reg <= running_next;
			ready_done_reg <= running_next && (ready_done_reg || ready_set);
			if (w_sample && w_bit) result_reg <= comp_s;
		end
	end

	always_ff @(posedge clock) begin
		if (!rst_n) begin
			ev_ready_reg <= 1'b0;
			ev_down_reg <= 1'b0;
			ev_up_reg <= 1'b0;
			ev_cross_reg <= 1'b0;
		end else begin
			// Hardware set wins over a software clear in the same cycle.
			ev_ready_reg <= ready_set || (w_ev_ready ? w_bit : ev_ready_reg);
			ev_up_reg <= up_set || (w_ev_up ? w_bit : ev_up_reg);
			ev_down_reg <= down_set || (w_ev_down ? w_bit : ev_down_reg);
			ev_cross_reg <= crossing || (w_ev_cross ? w_bit : ev_cross_reg);
		end
	end

	// ==========================================================
	// Analog core controls.
	assign pins_acquired = enabled;
	assign core_power = running_reg;
	assign differential_mode = diff_reg;
	assign speed_setting = speed_reg;
	assign positive_input_select = psel_reg;
	assign reference_source_choice = reference_source_choice_reg;
	assign external_pin_reference_choice = extref_reg;
	assign active_ladder_tap = comp_s ? lower_tap_reg : upper_tap_reg;
	assign band_active = diff_reg && band_reg;

endmodule

// ### tb/vcc_props.sv
// Checker for the comparator control bus and core outputs.
// Assumes one clock domain and a synchronous active-low reset.
`timescale 1ns/10ps
module vcc_props (
	input wire logic clock,
	input wire logic rst_n,
	input wire logic s_axi_awvalid,
	input wire logic s_axi_awready,
	input wire logic s_axi_wvalid,
	input wire logic s_axi_wready,
	input wire logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic s_axi_arvalid,
	input wire logic s_axi_arready,
	input wire logic [31:0] s_axi_rdata,
	input wire logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic pins_acquired,
	input wire logic core_power,
	input wire logic differential_mode,
	input wire logic band_active
);
	default clocking cb @(posedge clock);
	endclocking
	default disable iff (!rst_n);
	// ========================================================
	// Assertions.
	a_run_enabled: assert property (core_power |-> pins_acquired)
		else $error("core runs while disabled");
	a_band_single: assert property (band_active |-> differential_mode)
		else $error("band active in single-ended mode");
	a_wr_refused: assert property (s_axi_bvalid |->
		!s_axi_awready && !s_axi_wready)
		else $error("write taken while response pending");
	a_rd_refused: assert property (s_axi_rvalid |-> !s_axi_arready)
		else $error("read taken while data pending");
	a_b_holds: assert property (s_axi_bvalid && !s_axi_bready |=>
		s_axi_bvalid)
		else $error("write response dropped early");
	a_r_holds: assert property (s_axi_rvalid && !s_axi_rready |=>
		s_axi_rvalid && $stable(s_axi_rdata))
		else $error("read data dropped or changed");
	a_rd_answer: assert property (s_axi_arvalid && s_axi_arready |=>
		s_axi_rvalid)
		else $error("read answer late");
	a_wr_answer: assert property (s_axi_awvalid && s_axi_awready &&
		s_axi_wvalid && s_axi_wready |=> ##1 s_axi_bvalid)
		else $error("write answer late");
	// ========================================================
	// Covers.
	cover property ($rose(core_power));
	cover property ($fell(core_power));
	cover property (band_active);
endmodule

bind vcc_top vcc_props u_props (.clock, .rst_n, .s_axi_awvalid,
	.s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid,
	.s_axi_bready, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
	.s_axi_rvalid, .s_axi_rready, .pins_acquired, .core_power,
	.differential_mode, .band_active);

// ### tb/vcc_analog_model.sv
// Behavioural analog core: comparator, core ready and reference ready.
// Assumes the input level vin is driven by the bench on a 64-step scale.
`timescale 1ns/10ps
module vcc_analog_model (
	input wire logic clock,
	input wire logic core_power,
	input wire logic differential_mode,
	input wire logic [5:0] active_ladder_tap,
	input wire logic [5:0] vin,
	output logic comp_out_async,
	output logic core_ready_async,
	output logic ref_ready_async
);
	int cnt = 0;
	// Start-up counter of the powered core.
	always @(posedge clock) begin
		if (!core_power) cnt <= 0;
		else if (cnt < 40) cnt <= cnt + 1;
	end
	assign core_ready_async = core_power && cnt >= 4;
	assign ref_ready_async = core_power && cnt >= 20;
	// Differential compares with a pin at mid scale, else with the tap.
	assign comp_out_async = differential_mode ? (vin > 6'h20) :
		(vin > active_ladder_tap);
endmodule

// ### tb/tb_top.sv
// Testbench of the comparator control with a reference model.
// Assumes the analog model stands in for the core.
`timescale 1ns/10ps
module tb_top;
	logic clock = 0, rst_n = 0;
	logic [11:0] s_axi_awaddr = 0, s_axi_araddr = 0;
	logic [31:0] s_axi_wdata = 0, s_axi_rdata;
	logic [3:0] s_axi_wstrb = 4'hf;
	logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
	logic s_axi_arvalid = 0, s_axi_rready = 0;
	logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
	logic s_axi_rvalid, comp_out_async, core_ready_async, ref_ready_async;
	logic pins_acquired, core_power, differential_mode, band_active;
	logic [1:0] s_axi_bresp, s_axi_rresp, speed_setting;
	logic [2:0] positive_input_select, reference_source_choice;
	logic [2:0] external_pin_reference_choice;
	logic [5:0] active_ladder_tap, vin = 0;
	int n_fail = 0, samples_checked = 0, m_out = 0, m_run = 0;
	int msk[int];
	int mdl[int];
	int refs[5] = '{vcc_pkg::REF_INT_1V2, vcc_pkg::REF_INT_1V8,
		vcc_pkg::REF_INT_2V4, vcc_pkg::REF_SUPPLY, vcc_pkg::REF_PIN};
	logic [31:0] rd;
	logic [1:0] rs;
	always #5 clock = ~clock;
	vcc_top uut (.clock, .rst_n, .s_axi_awaddr, .s_axi_awvalid,
		.s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
		.s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
		.s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
		.s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .comp_out_async,
		.core_ready_async, .ref_ready_async, .pins_acquired, .core_power,
		.differential_mode, .speed_setting, .positive_input_select,
		.reference_source_choice, .external_pin_reference_choice,
		.active_ladder_tap, .band_active);
	vcc_analog_model u_ana (.clock, .core_power, .differential_mode,
		.active_ladder_tap, .vin, .comp_out_async, .core_ready_async,
		.ref_ready_async);
	// ========================================================
	// Checks and closing.
	task finish_test();
		$display("checked %0d failed %0d", samples_checked, n_fail);
		if (n_fail == 0 && samples_checked > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask
	task tmo();
		n_fail++;
		$display("ERROR %0t wait ran out", $time);
		finish_test();
	endtask
	initial begin
		repeat (20000) @(posedge clock);
		tmo();
	end
	task chk_val(input logic [31:0] got, input logic [31:0] exp);
		samples_checked++;
		if (got !== exp) begin
			n_fail++;
			$display("ERROR %0t got %h expected %h", $time, got, exp);
		end
	endtask
	task chk_resp(input logic [1:0] got, input int a);
		samples_checked++;
		if (got !== (msk.exists(a) ? vcc_pkg::RESP_OKAY :
			vcc_pkg::RESP_SLVERR)) begin
			n_fail++;
			$display("ERROR %0t response %h at %h", $time, got, a);
		end
	endtask
	task chk_ports();
		int t;
		t = mdl[vcc_pkg::OFF_LADDER_LEVELS];
		@(negedge clock);
		chk_val(speed_setting, mdl[vcc_pkg::OFF_MODE] & 3);
		chk_val(differential_mode, mdl[vcc_pkg::OFF_MODE] >> 8);
		chk_val(positive_input_select, mdl[vcc_pkg::OFF_PIN_SELECT]);
		chk_val(reference_source_choice, mdl[vcc_pkg::OFF_REF_CHOICE]);
		chk_val(external_pin_reference_choice,
			mdl[vcc_pkg::OFF_EXT_REF_CHOICE]);
		chk_val(pins_acquired, mdl[vcc_pkg::OFF_ENABLE] == 2);
		chk_val(core_power, m_run);
		chk_val(band_active, mdl[vcc_pkg::OFF_BAND_ENABLE] &
			mdl[vcc_pkg::OFF_MODE] >> 8);
		chk_val(active_ladder_tap, m_out ? t & 63 : t >> 8 & 63);
	endtask
	// ========================================================
	// Bus tasks with model update.
	task wr(input int a, input int d);
		int i;
		logic ta, tw, tv;
		@(posedge clock);
		s_axi_awaddr <= a[11:0];
		s_axi_wdata <= d;
		s_axi_awvalid <= 1;
		s_axi_wvalid <= 1;
		s_axi_bready <= 1;
		tv = 0;
		for (i = 0; i < 50 && !tv; i++) begin
			@(negedge clock);
			ta = s_axi_awready;
			tw = s_axi_wready;
			tv = s_axi_bvalid;
			rs = s_axi_bresp;
			@(posedge clock);
			if (ta) s_axi_awvalid <= 0;
			if (tw) s_axi_wvalid <= 0;
			if (tv) s_axi_bready <= 0;
		end
		if (!tv) tmo();
		chk_resp(rs, a);
		if (a == vcc_pkg::OFF_TASK_START && mdl[vcc_pkg::OFF_ENABLE] == 2)
			m_run = 1;
		if (a == vcc_pkg::OFF_TASK_STOP) m_run = 0;
		if (a == vcc_pkg::OFF_ENABLE && d != 2) m_run = 0;
		if (a == vcc_pkg::OFF_TASK_SAMPLE) mdl[vcc_pkg::OFF_RESULT] = m_out;
		if (a == vcc_pkg::OFF_BAND_ENABLE &&
			(mdl[vcc_pkg::OFF_MODE] >> 8) == 0) return;
		if (msk.exists(a) && a >= 'h100) mdl[a] = d & msk[a];
	endtask
	task rd_chk(input int a);
		int i;
		logic ta, tv;
		@(posedge clock);
		s_axi_araddr <= a[11:0];
		s_axi_arvalid <= 1;
		s_axi_rready <= 1;
		tv = 0;
		for (i = 0; i < 50 && !tv; i++) begin
			@(negedge clock);
			ta = s_axi_arready;
			tv = s_axi_rvalid;
			rd = s_axi_rdata;
			rs = s_axi_rresp;
			@(posedge clock);
			if (ta) s_axi_arvalid <= 0;
			if (tv) s_axi_rready <= 0;
		end
		if (!tv) tmo();
		chk_resp(rs, a);
		chk_val(rd, msk.exists(a) ? mdl[a] : 0);
	endtask
	task set_vin(input int v);
		int t;
		@(posedge clock);
		vin <= v;
		repeat (8) @(posedge clock);
		t = mdl[vcc_pkg::OFF_LADDER_LEVELS];
		t = m_out ? t & 63 : t >> 8 & 63;
		if (differential_mode) t = 32;
		if ((v > t) != m_out) begin
			m_out = !m_out;
			if (m_run) begin
				mdl[vcc_pkg::OFF_EV_CROSS] = 1;
				mdl[m_out ? vcc_pkg::OFF_EV_UP : vcc_pkg::OFF_EV_DOWN] = 1;
			end
		end
	endtask
	// ========================================================
	// Main sequence.
	initial begin
		void'($urandom(32'h002e04f8));
		msk = '{'h000: 0, 'h004: 0, 'h008: 0, 'h100: 1, 'h104: 1,
			'h108: 1, 'h10c: 1, 'h400: 1, 'h500: 3, 'h504: 7, 'h508: 7,
			'h50c: 7, 'h530: 'h3f3f, 'h534: 'h103, 'h538: 1};
		foreach (msk[k]) mdl[k] = 0;
		repeat (5) @(posedge clock);
		rst_n <= 1;
		foreach (msk[k]) if (k >= 'h100) rd_chk(k);
		rd_chk('h600);
		wr('h600, 1);
		wr(vcc_pkg::OFF_TASK_START, 1);
		chk_ports();
		for (int i = 0; i < 3; i++) begin
			wr(vcc_pkg::OFF_MODE, i);
			chk_ports();
		end
		foreach (refs[i]) begin
			wr(vcc_pkg::OFF_REF_CHOICE, refs[i]);
			chk_ports();
		end
		wr(vcc_pkg::OFF_PIN_SELECT, $urandom % 8);
		wr(vcc_pkg::OFF_REF_CHOICE, vcc_pkg::REF_INT_1V8);
		wr(vcc_pkg::OFF_EXT_REF_CHOICE, 3);
		wr(vcc_pkg::OFF_LADDER_LEVELS, 'h2a0a);
		wr(vcc_pkg::OFF_BAND_ENABLE, 1);
		rd_chk(vcc_pkg::OFF_BAND_ENABLE);
		wr(vcc_pkg::OFF_ENABLE, vcc_pkg::ENABLE_ON);
		chk_ports();
		wr(vcc_pkg::OFF_TASK_START, 1);
		repeat (10) @(posedge clock);
		rd_chk(vcc_pkg::OFF_EV_READY);
		repeat (30) @(posedge clock);
		mdl[vcc_pkg::OFF_EV_READY] = 1;
		rd_chk(vcc_pkg::OFF_EV_READY);
		chk_ports();
		set_vin(43 + $urandom % 21);
		for (int a = 'h100; a < 'h110; a += 4) rd_chk(a);
		chk_ports();
		wr(vcc_pkg::OFF_TASK_SAMPLE, 1);
		rd_chk(vcc_pkg::OFF_RESULT);
		wr(vcc_pkg::OFF_EV_UP, 0);
		wr(vcc_pkg::OFF_EV_CROSS, 0);
		set_vin(11 + $urandom % 31);
		rd_chk(vcc_pkg::OFF_EV_CROSS);
		set_vin($urandom % 11);
		for (int a = 'h104; a < 'h110; a += 4) rd_chk(a);
		wr(vcc_pkg::OFF_TASK_STOP, 1);
		set_vin(60);
		rd_chk(vcc_pkg::OFF_EV_UP);
		chk_ports();
		wr(vcc_pkg::OFF_ENABLE, 0);
		wr(vcc_pkg::OFF_MODE, 'h102);
		chk_ports();
		wr(vcc_pkg::OFF_EXT_REF_CHOICE, 6);
		wr(vcc_pkg::OFF_BAND_ENABLE, 1);
		set_vin(60);
		chk_ports();
		wr(vcc_pkg::OFF_EV_DOWN, 0);
		wr(vcc_pkg::OFF_ENABLE, vcc_pkg::ENABLE_ON);
		wr(vcc_pkg::OFF_TASK_START, 1);
		set_vin(10 + $urandom % 20);
		rd_chk(vcc_pkg::OFF_EV_DOWN);
		finish_test();
	end
endmodule
